// ### core/fsps_pkg.sv
// constants for the flash self-programming sequencer
package fsps_pkg;
	localparam int          WORD_BITS      = 7;
	localparam int          PAGE_BITS      = 8;
	localparam int          PAGE_WORDS     = 128;
	localparam int          FLASH_AW       = 15;
	localparam int          CSR_IE_BIT     = 7;
	localparam int          CSR_BUSY_BIT   = 6;
	localparam int          CSR_REEN_BIT   = 4;
	localparam int          CSR_PGWR_BIT   = 2;
	localparam int          CSR_PGER_BIT   = 1;
	localparam int          CSR_EN_BIT     = 0;
	localparam logic [6:0]  CMD_ERASE      = 7'h03;
	localparam logic [6:0]  CMD_WRITE      = 7'h05;
	localparam logic [6:0]  CMD_LOAD       = 7'h01;
	localparam logic [6:0]  CMD_REEN       = 7'h11;
	localparam logic [6:0]  CMD_NONE       = 7'h00;
	localparam logic [7:0]  CSR_RESET      = 8'h00;
	localparam logic [2:0]  CMD_WINDOW     = 3'h4;
	localparam logic [14:0] APP_RESET_ADDR = 15'h0000;
	localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
	typedef enum logic [1:0] {
		FSPS_IDLE  = 2'b00,
		FSPS_ARMED = 2'b01,
		FSPS_BUSY  = 2'b10
	} fsps_state_t;
endpackage

// ### core/fsps_seq.sv
// flash self-programming sequencer: command window, page buffer, erase/write control
`timescale 1ns/1ps
module fsps_seq #(
	parameter logic [14:0] BOOT_RESET_ADDR = 15'h7000,
	parameter logic [7:0]  NCR_FIRST_PAGE  = 8'hE0
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        boot_vector_fuse,
	input  wire logic        csr_wr,
	input  wire logic [7:0]  csr_wdata,
	output logic      [7:0]  csr_rdata,
	input  wire logic        spm_exec,
	input  wire logic        lpm_exec,
	input  wire logic [7:0]  pointer_high_byte,
	input  wire logic [7:0]  pointer_low_byte,
	input  wire logic [7:0]  data_r1,
	input  wire logic [7:0]  data_r0,
	input  wire logic        ee_write,
	input  wire logic        flash_done,
	input  wire logic [6:0]  buf_rd_idx,
	output logic      [15:0] buf_rd_data,
	output logic             flash_erase,
	output logic             flash_write,
	output logic      [7:0]  flash_page,
	output logic      [14:0] lpm_word_addr,
	output logic             lpm_high_byte,
	output logic             cpu_halt,
	output logic             spm_irq,
	output logic      [14:0] reset_vector
);
	fsps_pkg::fsps_state_t state_reg;
	logic [7:0]  csr_reg;
	logic [2:0]  win_reg;
	logic        fuse_s1_reg;
	logic        fuse_s2_reg;
	logic [15:0] buf_mem [fsps_pkg::PAGE_WORDS];
	logic [fsps_pkg::PAGE_WORDS-1:0] valid_reg;
	logic [15:0] pointer;
	logic        confirm;
	logic [6:0]  cmd;
	logic        is_ncr;
	logic        clr_buf;

	function automatic logic [6:0] word_field(input logic [15:0] z);
		word_field = z[fsps_pkg::WORD_BITS:1];
	endfunction

	function automatic logic [7:0] page_field(input logic [15:0] z);
		page_field = z[15:16-fsps_pkg::PAGE_BITS];
	endfunction

	assign pointer = {pointer_high_byte, pointer_low_byte};
	// busy is status, not part of the code; left in, it would hide every command after an erase or write outside the no-concurrent area
	assign cmd     = {1'b0, csr_reg[5:0]};
	assign confirm = (state_reg == fsps_pkg::FSPS_ARMED) && spm_exec;
	assign is_ncr  = page_field(pointer) >= NCR_FIRST_PAGE;
	// re-enable and write completion both empty the buffer
	assign clr_buf = (confirm && cmd == fsps_pkg::CMD_REEN) ||
	                 (state_reg == fsps_pkg::FSPS_BUSY && flash_done && flash_write == 1'b0 &&
	                  cmd == fsps_pkg::CMD_WRITE);

	// fuse is a pin level; only the external programmer can change it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fuse_s1_reg <= 1'b1;
			fuse_s2_reg <= 1'b1;
		end else begin
			fuse_s1_reg <= boot_vector_fuse;
			fuse_s2_reg <= fuse_s1_reg;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reset_vector <= fsps_pkg::APP_RESET_ADDR;
		end else begin
			reset_vector <= fuse_s2_reg ? fsps_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= fsps_pkg::FSPS_IDLE;
			win_reg   <= 3'h0;
		end else begin
			case (state_reg)
				fsps_pkg::FSPS_IDLE: begin
					if (csr_wr && csr_wdata[fsps_pkg::CSR_EN_BIT]) begin
						state_reg <= fsps_pkg::FSPS_ARMED;
						win_reg   <= fsps_pkg::CMD_WINDOW;
					end
				end
				fsps_pkg::FSPS_ARMED: begin
					if (spm_exec) begin
						if (cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE) begin
							state_reg <= fsps_pkg::FSPS_BUSY;
						end else begin
							state_reg <= fsps_pkg::FSPS_IDLE;
						end
					end else if (win_reg == 3'h1) begin
						state_reg <= fsps_pkg::FSPS_IDLE;
					end
					win_reg <= win_reg - 3'h1;
				end
				fsps_pkg::FSPS_BUSY: begin
					if (flash_done) begin
						state_reg <= fsps_pkg::FSPS_IDLE;
					end
				end
				default: begin
					state_reg <= fsps_pkg::FSPS_IDLE;
				end
			endcase
		end
	end

	// command bits written with enable live only while armed or busy; a late write during busy is dropped
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			csr_reg <= fsps_pkg::CSR_RESET;
		end else begin
			if (csr_wr && state_reg == fsps_pkg::FSPS_IDLE) begin
				csr_reg[fsps_pkg::CSR_IE_BIT] <= csr_wdata[fsps_pkg::CSR_IE_BIT];
				csr_reg[5:0]                  <= csr_wdata[5:0];
			end else if (csr_wr) begin
				csr_reg[fsps_pkg::CSR_IE_BIT] <= csr_wdata[fsps_pkg::CSR_IE_BIT];
			end
			if (state_reg == fsps_pkg::FSPS_ARMED && !spm_exec && win_reg == 3'h1) begin
				csr_reg[5:0] <= 6'h00;
			end
			if (confirm && cmd != fsps_pkg::CMD_ERASE && cmd != fsps_pkg::CMD_WRITE) begin
				csr_reg[5:0] <= 6'h00;
			end
			if (state_reg == fsps_pkg::FSPS_BUSY && flash_done) begin
				csr_reg[5:0] <= 6'h00;
			end
			if (confirm && (cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE) && !is_ncr) begin
				csr_reg[fsps_pkg::CSR_BUSY_BIT] <= 1'b1;
			end else if (confirm && cmd == fsps_pkg::CMD_REEN) begin
				csr_reg[fsps_pkg::CSR_BUSY_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			csr_rdata <= fsps_pkg::CSR_RESET;
		end else begin
			csr_rdata <= {csr_reg[7:6], 1'b0, csr_reg[4:0]};
		end
	end

	// start strobes and the page are latched so the pointer is free afterwards
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flash_erase <= 1'b0;
			flash_write <= 1'b0;
			flash_page  <= 8'h00;
		end else begin
			flash_erase <= confirm && cmd == fsps_pkg::CMD_ERASE;
			flash_write <= confirm && cmd == fsps_pkg::CMD_WRITE;
			if (confirm && (cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE)) begin
				flash_page <= page_field(pointer);
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cpu_halt <= 1'b0;
		end else if (confirm && (cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE) && is_ncr) begin
			cpu_halt <= 1'b1;
		end else if (state_reg == fsps_pkg::FSPS_BUSY && flash_done) begin
			cpu_halt <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			spm_irq <= 1'b0;
		end else begin
			spm_irq <= csr_reg[fsps_pkg::CSR_IE_BIT] && !csr_reg[fsps_pkg::CSR_EN_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lpm_word_addr <= 15'h0000;
			lpm_high_byte <= 1'b0;
		end else if (lpm_exec) begin
			lpm_word_addr <= pointer[15:1];
			lpm_high_byte <= pointer[0];
		end
	end

	// valid flags stand in for a cleared buffer; words never loaded read as erased
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			valid_reg <= '0;
		end else begin
			if (clr_buf) begin
				valid_reg <= '0;
			end else if (ee_write && |valid_reg && state_reg != fsps_pkg::FSPS_BUSY) begin
				valid_reg <= '0;
			end else if (confirm && cmd == fsps_pkg::CMD_LOAD) begin
				valid_reg[word_field(pointer)] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (confirm && cmd == fsps_pkg::CMD_LOAD) begin
			buf_mem[word_field(pointer)] <= {data_r1, data_r0};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			buf_rd_data <= fsps_pkg::ERASED_WORD;
		end else begin
			buf_rd_data <= valid_reg[buf_rd_idx] ? buf_mem[buf_rd_idx] : fsps_pkg::ERASED_WORD;
		end
	end

	logic armed_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= state_reg == fsps_pkg::FSPS_ARMED;
		end
	end

	window_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_reg == fsps_pkg::FSPS_ARMED && win_reg == 3'h1 && !spm_exec) |=> csr_reg[5:0] == 6'h00)
		else $error("command bits not cleared after window");
	// a store inside the window ends it early, so only an unused window must last four cycles
	window_len_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_reg == fsps_pkg::FSPS_IDLE && csr_wr && csr_wdata[0]) ##1
		(state_reg == fsps_pkg::FSPS_ARMED && !spm_exec)[*4] |=> state_reg != fsps_pkg::FSPS_ARMED)
		else $error("command window not four cycles");
	erase_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(confirm && cmd == fsps_pkg::CMD_ERASE) |=> flash_erase && flash_page == $past(pointer[15:8]))
		else $error("erase not started on page field");
	write_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(confirm && cmd == fsps_pkg::CMD_WRITE) |=> flash_write ##1 !flash_write)
		else $error("write strobe wrong");
	halt_ncr_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(confirm && (cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE) && is_ncr) |=> cpu_halt)
		else $error("no halt for no-concurrent area");
	// busy may already stand from the erase before, so only its presence after the write is checked
	halt_rww_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(confirm && cmd == fsps_pkg::CMD_WRITE && !is_ncr && !cpu_halt) |=>
		!cpu_halt && csr_reg[6] ##1 csr_rdata[6])
		else $error("concurrent write halted or busy not shown");
	irq_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(csr_reg[7] && !csr_reg[0]) [*2] |-> spm_irq)
		else $error("interrupt not held");
	done_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(state_reg == fsps_pkg::FSPS_BUSY && flash_done) |=> !csr_reg[0] && !cpu_halt)
		else $error("enable not cleared at completion");
	load_store_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(confirm && cmd == fsps_pkg::CMD_LOAD && !ee_write) |=> valid_reg[$past(pointer[7:1])])
		else $error("load not recorded");
	reen_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(confirm && cmd == fsps_pkg::CMD_REEN) |=> valid_reg == '0 && !csr_reg[6])
		else $error("re-enable left buffer or busy");
	vector_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(!fuse_s2_reg) |=> reset_vector == BOOT_RESET_ADDR)
		else $error("boot vector not chosen");

	erase_c: cover property (@(posedge core_clk) disable iff (!nrst) confirm && cmd == fsps_pkg::CMD_ERASE);
	load_c: cover property (@(posedge core_clk) disable iff (!nrst) confirm && cmd == fsps_pkg::CMD_LOAD);
	write_c: cover property (@(posedge core_clk) disable iff (!nrst) confirm && cmd == fsps_pkg::CMD_WRITE);
	timeout_c: cover property (@(posedge core_clk) disable iff (!nrst) armed_q && state_reg == fsps_pkg::FSPS_IDLE && !spm_exec);
	halt_c: cover property (@(posedge core_clk) disable iff (!nrst) cpu_halt ##1 !cpu_halt);
endmodule

// ### dv/fsps_flash_model.sv
// flash array stand-in: answers erase and write, copies the page buffer
`timescale 1ns/1ps
module fsps_flash_model (
	input  wire logic        core_clk,
	input  wire logic        flash_erase,
	input  wire logic        flash_write,
	input  wire logic [15:0] buf_rd_data,
	input  wire logic        slow,
	output logic      [6:0]  buf_rd_idx,
	output logic             flash_done
);
	logic [15:0] img [128];
	logic        go;
	initial begin
		buf_rd_idx = 7'h00;
		flash_done = 1'b0;
		forever begin
			@(posedge core_clk);
			#1;
			// index wanders while idle so a stale value is never mistaken for a request
			buf_rd_idx = buf_rd_idx + 7'h01;
			// the write strobe is long gone once the copy ends, so remember that an operation started
			go = flash_write || flash_erase;
			if (flash_write) begin
				for (int i = 0; i < 128; i++) begin
					buf_rd_idx = i[6:0];
					repeat (2) @(posedge core_clk);
					#1 img[i] = buf_rd_data;
				end
			end
			if (go) begin
				repeat (slow ? 40 : 3) @(posedge core_clk);
				#1 flash_done = 1'b1;
				@(posedge core_clk);
				#1 flash_done = 1'b0;
			end
		end
	end
endmodule

// ### dv/flash_self_programming_sequencer_tb_top.sv
// bench for the self-programming sequencer with a reference page buffer
`timescale 1ns/1ps
module flash_self_programming_sequencer_tb_top;
	localparam logic [14:0] boot_addr = 15'h7000;
	logic        core_clk = 1'b0, nrst = 1'b0, fuse = 1'b1, csr_wr = 1'b0, store_program_memory_instr = 1'b0;
	logic        load_program_memory_instr = 1'b0, ee = 1'b0, slow = 1'b0, fe, fw, done, halt, irq, hb, halt_seen;
	logic [7:0]  csr_wdata = 8'h00, ph = 8'h00, pl = 8'h00, d1 = 8'h00, d0 = 8'h00, csr_rdata, page;
	logic [6:0]  idx;
	logic [15:0] buf_rd_data;
	logic [14:0] la, rv;
	int          errors = 0, checked = 0, seed, exp_buf [128];
	always #5 core_clk = ~core_clk;
	fsps_seq #(.BOOT_RESET_ADDR(boot_addr), .NCR_FIRST_PAGE(8'hE0)) i_fsps_seq (
		.core_clk(core_clk), .nrst(nrst), .boot_vector_fuse(fuse), .csr_wr(csr_wr),
		.csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .spm_exec(store_program_memory_instr), .lpm_exec(load_program_memory_instr),
		.pointer_high_byte(ph), .pointer_low_byte(pl), .data_r1(d1), .data_r0(d0),
		.ee_write(ee), .flash_done(done), .buf_rd_idx(idx), .buf_rd_data(buf_rd_data),
		.flash_erase(fe), .flash_write(fw), .flash_page(page), .lpm_word_addr(la),
		.lpm_high_byte(hb), .cpu_halt(halt), .spm_irq(irq), .reset_vector(rv));
	fsps_flash_model i_fsps_flash_model (.core_clk(core_clk), .flash_erase(fe), .flash_write(fw),
		.buf_rd_data(buf_rd_data), .slow(slow), .buf_rd_idx(idx), .flash_done(done));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic clr;
		foreach (exp_buf[i]) exp_buf[i] = 32'hFFFF;
	endtask
	task automatic op(input logic [7:0] code, input logic [15:0] ptr, input logic [15:0] dat);
		{ph, pl} = ptr;
		{d1, d0} = dat;
		csr_wr = 1'b1;
		csr_wdata = code;
		cyc(1);
		csr_wr = 1'b0;
		store_program_memory_instr = 1'b1;
		cyc(1);
		store_program_memory_instr = 1'b0;
		// scramble the pointer at once: the operation must run on its latched copy
		{ph, pl} = 16'($random(seed));
		halt_seen = 1'b0;
		for (int i = 0; i < 400 && (i < 2 || csr_rdata[0] !== 1'b0); i++) begin
			halt_seen = halt_seen | halt;
			cyc(1);
		end
		if (code != 8'h11) chk(csr_rdata[0], 1'b0, "enable clear");
	endtask
	task automatic load(input logic [7:0] pg, input logic [6:0] w);
		logic [15:0] v;
		v = 16'($random(seed));
		exp_buf[w] = v;
		op(8'h01, {pg, w, 1'b0}, v);
	endtask
	task automatic erase_write(input logic [7:0] pg);
		slow = 1'($random(seed));
		op(8'h03, {pg, 8'h5B}, 16'($random(seed)));
		chk(csr_rdata[6], pg < 8'hE0, "busy");
		chk(halt_seen, pg >= 8'hE0, "halt erase");
		op(8'h05, {pg, 8'h00}, 16'($random(seed)));
		chk(halt_seen, pg >= 8'hE0, "halt write");
		chk(page, pg, "page");
		for (int i = 0; i < 128; i++) chk(i_fsps_flash_model.img[i], exp_buf[i][15:0], "image");
		clr();
		$display("-- page %h done", pg);
	endtask
	task automatic test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		$display("[FAIL] %0t watchdog", $time);
		test_done();
	end
	initial begin
		seed = 32'h2c76;
		clr();
		cyc(10);
		nrst = 1'b1;
		cyc(3);
		chk({1'b0, rv}, 16'h0000, "app vector");
		for (int i = 0; i < 8; i++) load(8'h10, 7'((i * 37 + 5) % 128));
		erase_write(8'h10);
		erase_write(8'h10);
		load(8'h20, 7'h03);
		op(8'h11, 16'h0000, 16'h0000);
		chk(csr_rdata[6], 1'b0, "busy clear");
		clr();
		erase_write(8'h20);
		op(8'h11, 16'h0000, 16'h0000);
		load(8'hE0, 7'h7F);
		load(8'hE0, 7'h00);
		erase_write(8'hE0);
		load(8'h30, 7'h09);
		ee = 1'b1;
		cyc(1);
		ee = 1'b0;
		clr();
		erase_write(8'h30);
		csr_wr = 1'b1;
		csr_wdata = 8'h80;
		cyc(1);
		csr_wr = 1'b0;
		cyc(3);
		chk(irq, 1'b1, "irq idle");
		csr_wr = 1'b1;
		csr_wdata = 8'h83;
		cyc(1);
		csr_wr = 1'b0;
		cyc(2);
		chk(irq, 1'b0, "irq armed");
		cyc(6);
		chk(csr_rdata[5:0], 6'h00, "auto clear");
		chk(irq, 1'b1, "irq after clear");
		$display("-- irq and window done");
		{ph, pl} = 16'hABCD;
		load_program_memory_instr = 1'b1;
		cyc(1);
		load_program_memory_instr = 1'b0;
		cyc(1);
		chk({1'b0, la}, 16'h55E6, "load word");
		chk(hb, 1'b1, "byte select");
		load(8'h40, 7'h01);
		fuse = 1'b0;
		nrst = 1'b0;
		cyc(2);
		nrst = 1'b1;
		cyc(3);
		chk({1'b0, rv}, {1'b0, boot_addr}, "boot vector");
		clr();
		erase_write(8'h40);
		test_done();
	end
endmodule
